// File: rtl/cpu_subset_exec.sv
// Purpose: Executes compare-immediate, decrement, increment, absolute and carry-relative branches
// Assumes: Data-space read data is valid the cycle after ds_rd; writes land on the edge ending ds_wr
// Notes:   Unknown opcodes are skipped as one-byte no-ops and flagged on bad_op
//
// Functional notes
// - Compare-immediate 37 nn subtracts nn from accumulator for flags; two bytes, four cycles.
// - Compare-immediate leaves the accumulator unchanged.
// - Compare sets Z on zero difference, C when accumulator below source.
// - Decrement subtracts one, Z from result, C untouched, four cycles.
// - Decrement: one byte for short and indirect, FF prefix for accumulator or address.
// - Increment adds one, Z from result, C untouched, 7F prefix for long forms.
// - Absolute branch loads a twelve-bit target; old counter is not stacked.
// - Absolute branch: two bytes, four cycles, low nibble over 1001, then upper nibbles.
// - Branch-on-carry adds displacement -15..+16 when carry set, else falls through.
// - Branch-on-carry is one byte, two cycles, displacement above pattern 110.
// - Branch-on-no-carry adds displacement when carry clear, else falls through.
// - Branch-on-no-carry is one byte, two cycles, displacement above pattern 010.
`timescale 1ns/100ps
module cpu_subset_exec (
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire logic                  start,
    input  wire cpu_subset_pkg::instr_t instr,
    input  wire logic                  preset,
    input  wire cpu_subset_pkg::arch_t preset_val,
    input  wire logic [7:0]            ds_rdata,
    output logic                       busy,
    output logic                       done,
    output logic                       bad_op,
    output cpu_subset_pkg::arch_t      arch,
    output logic [7:0]                 ds_addr,
    output logic                       ds_rd,
    output logic                       ds_wr,
    output logic [7:0]                 ds_wdata
);

    ////////////////////////////////////////////////////////////////////////////
    // State
    cpu_subset_pkg::state_t state_q;
    cpu_subset_pkg::instr_t ins_q;
    cpu_subset_pkg::arch_t  arch_q;
    cpu_subset_pkg::arch_t  arch_d;
    logic [2:0]             cnt_q;
    logic                   done_q;
    logic                   busy_q;
    logic                   bad_q;
    logic                   rd_q;
    logic                   wr_q;
    logic [7:0]             addr_q;
    logic [7:0]             wdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Decode of the captured instruction
    wire        is_cmp   = ins_q.b0 == cpu_subset_pkg::OP_CMP_IMM;
    wire        sub_sh   = ins_q.b0[5:0] == cpu_subset_pkg::MINUS_SHORT_LO;
    wire        inc_sh   = ins_q.b0[5:0] == cpu_subset_pkg::INC_SHORT_LO;
    wire        sub_ind  = ins_q.b0 == cpu_subset_pkg::OP_MINUS_IND_X || ins_q.b0 == cpu_subset_pkg::OP_MINUS_IND_Y;
    wire        inc_ind  = ins_q.b0 == cpu_subset_pkg::OP_INC_IND_X || ins_q.b0 == cpu_subset_pkg::OP_INC_IND_Y;
    wire        sub_lg   = ins_q.b0 == cpu_subset_pkg::OP_MINUS_LONG;
    wire        inc_lg   = ins_q.b0 == cpu_subset_pkg::OP_INC_LONG;
    wire        is_abs   = ins_q.b0[3:0] == cpu_subset_pkg::ABS_BR_LO;
    wire        is_brc   = ins_q.b0[2:0] == cpu_subset_pkg::BR_C_LO;
    wire        is_brnc  = ins_q.b0[2:0] == cpu_subset_pkg::BR_NC_LO;
    wire        is_sub   = sub_sh | sub_ind | sub_lg;
    wire        is_inc   = inc_sh | inc_ind | inc_lg;
    wire        is_ind   = sub_ind | inc_ind;
    wire        is_long  = sub_lg | inc_lg;
    wire        long_acc = is_long && ins_q.b1 == cpu_subset_pkg::ACC_SEL;
    wire        mem_op   = is_ind | (is_long & ~long_acc);
    wire        is_jr    = is_brc | is_brnc;
    wire        known    = is_cmp | is_sub | is_inc | is_abs | is_jr;
    wire        two_byte = is_cmp | is_long | is_abs;
    wire [2:0]  cyc      = is_jr | ~known ? cpu_subset_pkg::CYC_SHORT : cpu_subset_pkg::CYC_LONG;
    wire        fin      = state_q == cpu_subset_pkg::ST_EXEC && cnt_q == cyc - 3'h1;

    ////////////////////////////////////////////////////////////////////////////
    // Operand selection and arithmetic
    wire [1:0]  sh_sel   = ins_q.b0[7:6];
    wire [7:0]  sh_val   = sh_sel == 2'h0 ? arch_q.x : sh_sel == 2'h1 ? arch_q.y :
                           sh_sel == 2'h2 ? arch_q.v : arch_q.w;
    wire [7:0]  ptr      = ins_q.b0[cpu_subset_pkg::IND_Y_BIT] ? arch_q.y : arch_q.x;
    wire [7:0]  mem_addr = is_ind ? ptr : ins_q.b1;
    wire [7:0]  opnd     = mem_op ? ds_rdata : (sub_sh | inc_sh) ? sh_val : arch_q.acc;
    wire [7:0]  res      = is_inc ? opnd + 8'h01 : opnd - 8'h01;
    wire [7:0]  cmp_diff = arch_q.acc - ins_q.b1;
    wire        cmp_c    = arch_q.acc < ins_q.b1;
    // Signed field plus one gives the asymmetric -15..+16 reach
    wire [11:0] rel_off  = {{7{ins_q.b0[7]}}, ins_q.b0[7:3]} + cpu_subset_pkg::PC_STEP1;
    wire [11:0] rel_tgt  = arch_q.pc + rel_off;
    wire        take     = is_brc ? arch_q.c : ~arch_q.c;
    wire [11:0] abs_tgt  = {ins_q.b1, ins_q.b0[7:4]};
    wire [11:0] seq_pc   = arch_q.pc + (two_byte ? cpu_subset_pkg::PC_STEP2 : cpu_subset_pkg::PC_STEP1);
    wire [11:0] next_pc  = is_abs ? abs_tgt : (is_jr && take) ? rel_tgt : seq_pc;

    always_comb begin
        arch_d    = arch_q;
        arch_d.pc = next_pc;
        if (is_cmp) begin
            arch_d.z = cmp_diff == 8'h00;
            arch_d.c = cmp_c;
        end else if (is_sub | is_inc) begin
            arch_d.z = res == 8'h00;
            if (long_acc) begin
                arch_d.acc = res;
            end else if (sub_sh | inc_sh) begin
                case (sh_sel)
                    2'h0:    arch_d.x = res;
                    2'h1:    arch_d.y = res;
                    2'h2:    arch_d.v = res;
                    default: arch_d.w = res;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= cpu_subset_pkg::ST_IDLE;
            busy_q  <= 1'b0;
            cnt_q   <= 3'h0;
        end else if (state_q == cpu_subset_pkg::ST_IDLE) begin
            if (start) begin
                state_q <= cpu_subset_pkg::ST_EXEC;
                busy_q  <= 1'b1;
                cnt_q   <= 3'h1;
            end
        end else if (fin) begin
            state_q <= cpu_subset_pkg::ST_IDLE;
            busy_q  <= 1'b0;
            cnt_q   <= 3'h0;
        end else begin
            cnt_q   <= cnt_q + 3'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            ins_q <= '0;
        end else if (state_q == cpu_subset_pkg::ST_IDLE && start) begin
            ins_q <= instr;
        end
    end

    // Architectural state; preset is honoured only while idle
    always_ff @(posedge clk) begin
        if (rst) begin
            arch_q <= '{cpu_subset_pkg::REG_RESET, cpu_subset_pkg::REG_RESET, cpu_subset_pkg::REG_RESET,
                        cpu_subset_pkg::REG_RESET, cpu_subset_pkg::REG_RESET, 1'b0, 1'b0,
                        cpu_subset_pkg::PC_RESET};
        end else if (fin) begin
            arch_q <= arch_d;
        end else if (state_q == cpu_subset_pkg::ST_IDLE && preset && !start) begin
            arch_q <= preset_val;
        end
    end

    // Data-space read in the second cycle, write-back launched with done
    always_ff @(posedge clk) begin
        if (rst) begin
            rd_q    <= 1'b0;
            wr_q    <= 1'b0;
            addr_q  <= 8'h00;
            wdata_q <= 8'h00;
            done_q  <= 1'b0;
            bad_q   <= 1'b0;
        end else begin
            rd_q   <= state_q == cpu_subset_pkg::ST_EXEC && cnt_q == 3'h1 && mem_op;
            wr_q   <= fin && mem_op;
            done_q <= fin;
            bad_q  <= fin && !known;
            if (state_q == cpu_subset_pkg::ST_EXEC && cnt_q == 3'h1) begin
                addr_q <= mem_addr;
            end
            if (fin) begin
                wdata_q <= res;
            end
        end
    end

    assign busy     = busy_q;
    assign done     = done_q;
    assign bad_op   = bad_q;
    assign arch     = arch_q;
    assign ds_addr  = addr_q;
    assign ds_rd    = rd_q;
    assign ds_wr    = wr_q;
    assign ds_wdata = wdata_q;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    wire idle_go = state_q == cpu_subset_pkg::ST_IDLE && start;

    // A start in the done cycle sees the previous done, so done is only required low from the next edge
    property p_cmp_cycles;
        @(posedge clk) disable iff (rst) idle_go && instr.b0 == cpu_subset_pkg::OP_CMP_IMM |->
            ##1 !done_q [*3] ##1 done_q;
    endproperty
    a_cmp_cycles: assert property (p_cmp_cycles) else $error("compare did not finish in four cycles");

    property p_cmp_acc;
        @(posedge clk) disable iff (rst) fin && is_cmp |=> arch_q.acc == $past(arch_q.acc);
    endproperty
    a_cmp_acc: assert property (p_cmp_acc) else $error("compare altered the accumulator");

    property p_cmp_flags;
        @(posedge clk) disable iff (rst) fin && is_cmp |=>
            arch_q.c == ($past(arch_q.acc) < $past(ins_q.b1)) && arch_q.z == ($past(arch_q.acc) == $past(ins_q.b1));
    endproperty
    a_cmp_flags: assert property (p_cmp_flags) else $error("compare flags wrong");

    property p_incdec_carry;
        @(posedge clk) disable iff (rst) fin && (is_sub || is_inc) |=> arch_q.c == $past(arch_q.c);
    endproperty
    a_incdec_carry: assert property (p_incdec_carry) else $error("carry changed by step");

    property p_acc_minus;
        @(posedge clk) disable iff (rst) fin && sub_lg && long_acc |=>
            arch_q.acc == $past(arch_q.acc) - 8'h01 && arch_q.z == (arch_q.acc == 8'h00);
    endproperty
    a_acc_minus: assert property (p_acc_minus) else $error("accumulator decrement wrong");

    property p_abs_target;
        @(posedge clk) disable iff (rst) fin && is_abs |=> arch_q.pc == {$past(ins_q.b1), $past(ins_q.b0[7:4])};
    endproperty
    a_abs_target: assert property (p_abs_target) else $error("jump target wrong");

    // Reference reach worked out afresh: signed field plus one, from the branch's own address
    property p_jr_pc;
        @(posedge clk) disable iff (rst) fin && is_jr |=> arch_q.pc == $past(arch_q.pc) +
            (($past(is_brc) ? $past(arch_q.c) : !$past(arch_q.c)) ?
             {{7{$past(ins_q.b0[7])}}, $past(ins_q.b0[7:3])} + cpu_subset_pkg::PC_STEP1 : cpu_subset_pkg::PC_STEP1);
    endproperty
    a_jr_pc: assert property (p_jr_pc) else $error("relative branch pc wrong");

    property p_jr_cycles;
        @(posedge clk) disable iff (rst) idle_go && instr.b0[1:0] == 2'h2 |-> ##1 !done_q ##1 done_q;
    endproperty
    a_jr_cycles: assert property (p_jr_cycles) else $error("relative branch not two cycles");

    property p_br_flags;
        @(posedge clk) disable iff (rst) fin && (is_jr || is_abs) |=> arch_q.z == $past(arch_q.z) && arch_q.c == $past(arch_q.c);
    endproperty
    a_br_flags: assert property (p_br_flags) else $error("branch changed flags");

    property p_rmw;
        @(posedge clk) disable iff (rst) ds_rd |-> ##2 ds_wr && ds_addr == $past(ds_addr, 2) && ds_wdata == (is_inc ?
            $past(ds_rdata) + 8'h01 : $past(ds_rdata) - 8'h01);
    endproperty
    a_rmw: assert property (p_rmw) else $error("read-modify-write broken");

    c_ind: cover property (@(posedge clk) disable iff (rst) fin && is_ind);
    c_brc_taken: cover property (@(posedge clk) disable iff (rst) fin && is_brc && take);
    c_cmp_eq: cover property (@(posedge clk) disable iff (rst) fin && is_cmp && cmp_diff == 8'h00);

endmodule : cpu_subset_exec

// File: rtl/cpu_subset_pkg.sv
// Purpose: Shared encodings, timing figures and carriers for the instruction subset executor
// Assumes: One opcode byte plus at most one operand byte per instruction
// Notes:   Architectural state and instruction bytes travel as packed structs
package cpu_subset_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Opcode patterns
    localparam logic [7:0] OP_CMP_IMM     = 8'h37;
    localparam logic [7:0] OP_MINUS_LONG  = 8'hff;
    localparam logic [7:0] OP_INC_LONG    = 8'h7f;
    localparam logic [7:0] OP_MINUS_IND_X = 8'he7;
    localparam logic [7:0] OP_MINUS_IND_Y = 8'hef;
    localparam logic [7:0] OP_INC_IND_X   = 8'h67;
    localparam logic [7:0] OP_INC_IND_Y   = 8'h6f;
    localparam logic [7:0] ACC_SEL        = 8'hff;
    localparam logic [5:0] MINUS_SHORT_LO = 6'h1d;
    localparam logic [5:0] INC_SHORT_LO   = 6'h15;
    localparam logic [3:0] ABS_BR_LO      = 4'h9;
    localparam logic [2:0] BR_C_LO        = 3'h6;
    localparam logic [2:0] BR_NC_LO       = 3'h2;
    localparam int         IND_Y_BIT    = 3;

    ////////////////////////////////////////////////////////////////////////////
    // Cycle counts and reset values
    localparam logic [2:0]  CYC_LONG   = 3'h4;
    localparam logic [2:0]  CYC_SHORT  = 3'h2;
    localparam logic [11:0] PC_RESET   = 12'h000;
    localparam logic [7:0]  REG_RESET  = 8'h00;
    localparam logic [11:0] PC_STEP1   = 12'h001;
    localparam logic [11:0] PC_STEP2   = 12'h002;

    typedef struct packed {
        logic [7:0] b0;
        logic [7:0] b1;
    } instr_t;

    typedef struct packed {
        logic [7:0]  acc;
        logic [7:0]  x;
        logic [7:0]  y;
        logic [7:0]  v;
        logic [7:0]  w;
        logic        z;
        logic        c;
        logic [11:0] pc;
    } arch_t;

    typedef enum logic {ST_IDLE, ST_EXEC} state_t;

endpackage : cpu_subset_pkg

// File: tb/cpu_subset_exec_tb.sv
// Purpose: Self-checking bench for the instruction subset executor
// Assumes: Inputs change 1 ns after the rising edge; data space is modelled by a read-only array
// Notes:   Table rows cover every encoding; back-to-back, refusal and mid-run reset are hand-written
`timescale 1ns/100ps
module cpu_subset_exec_tb;

    typedef struct packed {
        cpu_subset_pkg::instr_t i;
        cpu_subset_pkg::arch_t  pre;
        cpu_subset_pkg::arch_t  exp;
        logic [2:0]             n;
        logic [7:0]             wa;
        logic [7:0]             wd;
        logic                   bad;
    } row_t;

    logic                   clk        = 1'b0;
    logic                   rst        = 1'b1;
    logic                   start      = 1'b0;
    cpu_subset_pkg::instr_t instr      = '0;
    logic                   preset     = 1'b0;
    cpu_subset_pkg::arch_t  preset_val = '0;
    logic [7:0]             ds_rdata   = 8'h00;
    logic                   busy;
    logic                   done;
    logic                   bad_op;
    cpu_subset_pkg::arch_t  arch;
    logic [7:0]             ds_addr;
    logic                   ds_rd;
    logic                   ds_wr;
    logic [7:0]             ds_wdata;
    logic [7:0]             mem [256];
    row_t                   rows [$];
    int                     n_fail     = 0;
    int                     n_compared = 0;
    int                     cycles     = 0;

    cpu_subset_exec u_cpu_subset_exec (
        .clk(clk), .rst(rst), .start(start), .instr(instr), .preset(preset), .preset_val(preset_val),
        .ds_rdata(ds_rdata), .busy(busy), .done(done), .bad_op(bad_op), .arch(arch),
        .ds_addr(ds_addr), .ds_rd(ds_rd), .ds_wr(ds_wr), .ds_wdata(ds_wdata)
    );

    ////////////////////////////////////////////////////////////////////////////
    always #10 clk = ~clk;

    // Outside a read the bus shows a changing pattern, so a late sample never looks right by luck
    always @(posedge clk) begin
        ds_rdata <= #1 ds_rd ? mem[ds_addr] : ~ds_rdata;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [59:0] seen, input logic [59:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic tally_and_finish();
        $display("Compared %0d, mismatched %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic add(input logic [15:0] i, input logic [39:0] pr, input logic [1:0] pz, input logic [39:0] er,
                       input logic [1:0] ez, input logic [11:0] pc, input logic [2:0] n, input logic [7:0] wa,
                       input logic [7:0] wd, input logic bad);
        rows.push_back('{i, {pr, pz, 12'h100}, {er, ez, pc}, n, wa, wd, bad});
    endtask : add

    task automatic run(input row_t r);
        int cnt;
        preset = 1'b1;
        preset_val = r.pre;
        @(posedge clk); #1;
        preset = 1'b0;
        start = 1'b1;
        instr = r.i;
        @(posedge clk); #1;
        start = 1'b0;
        cnt = 1;
        check("busy", busy, 1'b1);
        while (done !== 1'b1 && cnt < 9) begin
            @(posedge clk); #1;
            cnt++;
            if (cnt == 2) begin
                check("ds_rd", ds_rd, r.wa != 8'h00);
            end
        end
        check("cycles", 60'(cnt), r.n);
        check("arch", arch, r.exp);
        check("bad_op", bad_op, r.bad);
        check("ds_wr", ds_wr, r.wa != 8'h00);
        if (r.wa != 8'h00) begin
            check("ds_addr", ds_addr, r.wa);
            check("ds_wdata", ds_wdata, r.wd);
        end
    endtask : run

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mem = '{default: 8'h00};
        mem[8'h45] = 8'h16;
        mem[8'h50] = 8'hff;
        mem[8'h30] = 8'h01;
        mem[8'h31] = 8'h41;
        add(16'h371c, 40'hf801020304, 2'b01, 40'hf801020304, 2'b00, 12'h102, 3'h4, 8'h00, 8'h00, 1'b0);
        add(16'h3710, 40'h1001020304, 2'b01, 40'h1001020304, 2'b10, 12'h102, 3'h4, 8'h00, 8'h00, 1'b0);
        add(16'h3706, 40'h0501020304, 2'b10, 40'h0501020304, 2'b01, 12'h102, 3'h4, 8'h00, 8'h00, 1'b0);
        add(16'hffff, 40'h0001020304, 2'b01, 40'hff01020304, 2'b01, 12'h102, 3'h4, 8'h00, 8'h00, 1'b0);
        add(16'h1d00, 40'h0001020304, 2'b01, 40'h0000020304, 2'b11, 12'h101, 3'h4, 8'h00, 8'h00, 1'b0);
        add(16'h5d00, 40'h0001020304, 2'b10, 40'h0001010304, 2'b00, 12'h101, 3'h4, 8'h00, 8'h00, 1'b0);
        add(16'h9d00, 40'h0001020304, 2'b00, 40'h0001020204, 2'b00, 12'h101, 3'h4, 8'h00, 8'h00, 1'b0);
        add(16'hdd00, 40'h0001020300, 2'b10, 40'h00010203ff, 2'b00, 12'h101, 3'h4, 8'h00, 8'h00, 1'b0);
        add(16'he700, 40'h0045500304, 2'b01, 40'h0045500304, 2'b01, 12'h101, 3'h4, 8'h45, 8'h15, 1'b0);
        add(16'hef00, 40'h0045500304, 2'b11, 40'h0045500304, 2'b01, 12'h101, 3'h4, 8'h50, 8'hfe, 1'b0);
        add(16'hff30, 40'h0001020304, 2'b00, 40'h0001020304, 2'b10, 12'h102, 3'h4, 8'h30, 8'h00, 1'b0);
        add(16'h7fff, 40'hff01020304, 2'b01, 40'h0001020304, 2'b11, 12'h102, 3'h4, 8'h00, 8'h00, 1'b0);
        add(16'h1500, 40'h0001020304, 2'b10, 40'h0002020304, 2'b00, 12'h101, 3'h4, 8'h00, 8'h00, 1'b0);
        add(16'h5500, 40'h0001ff0304, 2'b01, 40'h0001000304, 2'b11, 12'h101, 3'h4, 8'h00, 8'h00, 1'b0);
        add(16'h9500, 40'h0001020304, 2'b00, 40'h0001020404, 2'b00, 12'h101, 3'h4, 8'h00, 8'h00, 1'b0);
        add(16'hd500, 40'h0001020304, 2'b00, 40'h0001020305, 2'b00, 12'h101, 3'h4, 8'h00, 8'h00, 1'b0);
        add(16'h6700, 40'h0045500304, 2'b10, 40'h0045500304, 2'b00, 12'h101, 3'h4, 8'h45, 8'h17, 1'b0);
        add(16'h6f00, 40'h0045500304, 2'b01, 40'h0045500304, 2'b11, 12'h101, 3'h4, 8'h50, 8'h00, 1'b0);
        add(16'h7f31, 40'h0001020304, 2'b11, 40'h0001020304, 2'b01, 12'h102, 3'h4, 8'h31, 8'h42, 1'b0);
        add(16'hd95c, 40'h0001020304, 2'b11, 40'h0001020304, 2'b11, 12'h5cd, 3'h4, 8'h00, 8'h00, 1'b0);
        add(16'h7e00, 40'h0001020304, 2'b01, 40'h0001020304, 2'b01, 12'h110, 3'h2, 8'h00, 8'h00, 1'b0);
        add(16'h8600, 40'h0001020304, 2'b11, 40'h0001020304, 2'b11, 12'h0f1, 3'h2, 8'h00, 8'h00, 1'b0);
        add(16'h7e00, 40'h0001020304, 2'b10, 40'h0001020304, 2'b10, 12'h101, 3'h2, 8'h00, 8'h00, 1'b0);
        add(16'hda00, 40'h0001020304, 2'b00, 40'h0001020304, 2'b00, 12'h0fc, 3'h2, 8'h00, 8'h00, 1'b0);
        add(16'hda00, 40'h0001020304, 2'b01, 40'h0001020304, 2'b01, 12'h101, 3'h2, 8'h00, 8'h00, 1'b0);
        add(16'h0000, 40'h0001020304, 2'b01, 40'h0001020304, 2'b01, 12'h101, 3'h2, 8'h00, 8'h00, 1'b1);
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        check("reset arch", arch, '0);
        check("reset strobes", {busy, done, bad_op, ds_rd, ds_wr}, 5'h00);
        foreach (rows[k]) begin
            run(rows[k]);
        end
        // Start held high across a whole decrement: refused while busy, then taken in the done cycle
        preset = 1'b1;
        preset_val = {40'h0010000000, 2'b00, 12'h100};
        @(posedge clk); #1;
        preset = 1'b0;
        start = 1'b1;
        instr = 16'h1d00;
        @(posedge clk); #1;
        instr = 16'h1500;
        preset = 1'b1;
        preset_val = '0;
        repeat (3) @(posedge clk);
        #1;
        check("first done", {done, arch.x, arch.pc}, {1'b1, 8'h0f, 12'h101});
        @(posedge clk); #1;
        start = 1'b0;
        preset = 1'b0;
        check("back to back busy", busy, 1'b1);
        repeat (3) @(posedge clk);
        #1;
        check("second done", {done, arch.x, arch.pc}, {1'b1, 8'h10, 12'h102});
        // Reset in mid-instruction must abandon the write
        preset = 1'b1;
        preset_val = {40'h0045000000, 2'b01, 12'h100};
        @(posedge clk); #1;
        preset = 1'b0;
        start = 1'b1;
        instr = 16'he700;
        @(posedge clk); #1;
        start = 1'b0;
        @(posedge clk); #1;
        rst = 1'b1;
        @(posedge clk); #1;
        rst = 1'b0;
        check("mid reset arch", arch, '0);
        check("mid reset strobes", {busy, done, ds_rd, ds_wr}, 4'h0);
        // The abandoned write would have shown on this edge
        @(posedge clk); #1;
        check("abandoned write", {busy, done, ds_wr}, 3'h0);
        // The block must take a fresh instruction straight after the mid-run reset
        run(rows[0]);
        tally_and_finish();
    end

endmodule : cpu_subset_exec_tb
